/* File: src/cmdd_core.sv */
// command-mode control and diagnostic readout with wishbone registers
// How it works
// - command mode ends alone after configured 100 ms units with no command
// - exit command leaves command mode at once
// - mode entered only with guard silence before and after escapes
// - escape character programmable, resets to 0x2B
// - apply command commits queued settings and reinitialises
// - channel-busy failures counted in 16 bits, saturating
// - acknowledgement failures counted in 16 bits, saturating
// - writing zero clears a counter, reading leaves it unchanged
// - last good packet strength held as read-only magnitude
// - energy scan dwells 2^n times 15.36 ms per channel, sends lowest energy level and CR
// - firmware and hardware versions are read-only
// - verbose version exists only up to firmware 10C8
`timescale 1ns/1ps
`include "cmdd_defs.svh"

module cmdd_core #(
	parameter int MS_CYCLES = `CMDD_CLK_MHZ * `CMDD_TICK_MS_US,
	parameter int SCAN_CYCLES = `CMDD_CLK_MHZ * `CMDD_SCAN_BASE_US,
	parameter logic [15:0] FW_REV = 16'h1000, // arbitrary value
	parameter logic [15:0] HW_REV = 16'h0100, // arbitrary value
	parameter logic [31:0] VERBOSE_INFO = 32'h0000_0000,
	parameter logic [7:0] CCA_THRESHOLD_RST = 8'h00
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire cmdd_pkg::cmdd_byte_s rx_in,
	input wire logic cmd_valid,
	input wire logic cca_fail,
	input wire logic ack_fail,
	input wire logic rx_good,
	input wire logic [7:0] rx_rssi,
	input wire logic [7:0] energy_level,
	output cmdd_pkg::cmdd_byte_s scan_tx,
	input wire logic scan_tx_ready,
	output logic [3:0] scan_channel,
	output logic scan_active,
	output logic cmd_mode,
	output logic [7:0] cca_threshold,
	output logic cfg_reinit,
	output logic irq
);

	function automatic logic [15:0] wmerge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		wmerge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic wb_ack_ff;
	logic [31:0] wb_dat_ff;
	logic [15:0] tmo_pend_ff, tmo_ff, gt_pend_ff, gt_ff;
	logic [7:0] esc_pend_ff, esc_ff, cca_pend_ff, cca_ff;
	logic cfg_reinit_ff;
	cmdd_pkg::cmdd_esc_e esc_st_ff, nxt_esc_st;
	logic [15:0] silence_ff, idle_cnt_ff;
	logic cmd_mode_ff;
	logic [15:0] fail_cnt_ff [2];
	logic [7:0] rssi_ff;
	cmdd_pkg::cmdd_scan_e sc_st_ff, nxt_sc_st;
	logic [2:0] sc_exp_ff;
	logic [6:0] sc_units_ff, nxt_sc_units;
	logic [3:0] sc_ch_ff, nxt_sc_ch;
	logic [7:0] sc_peak_ff, nxt_sc_peak;
	cmdd_pkg::cmdd_byte_s scan_tx_ff, nxt_scan_tx;
	logic [`CMDD_IRQ_W-1:0] irq_st_ff, irq_msk_ff;
	logic [31:0] rd_mux;
	logic scan_start_dwell;
	logic scan_done;
	logic tick_ms, tick_100ms, tick_scan;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
	// writes land at the edge where the master samples ack
	wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_ff;
	wire wr_cmd = wb_wr & (wb_adr_i == `CMDD_A_CMD);
	wire wr_tmo = wb_wr & (wb_adr_i == `CMDD_A_TMO);
	wire wr_gt = wb_wr & (wb_adr_i == `CMDD_A_GUARD);
	wire wr_esc = wb_wr & (wb_adr_i == `CMDD_A_ESC) & wb_sel_i[0];
	wire wr_cca = wb_wr & (wb_adr_i == `CMDD_A_CCA) & wb_sel_i[0];
	wire wr_busy = wb_wr & (wb_adr_i == `CMDD_A_BUSYCNT);
	wire wr_ack = wb_wr & (wb_adr_i == `CMDD_A_ACKCNT);
	wire wr_irqst = wb_wr & (wb_adr_i == `CMDD_A_IRQST) & wb_sel_i[0];
	wire wr_irqmsk = wb_wr & (wb_adr_i == `CMDD_A_IRQMSK) & wb_sel_i[0];
	wire [15:0] tmo_w = wmerge16(tmo_pend_ff, wb_dat_i, wb_sel_i);
	wire [15:0] gt_w = wmerge16(gt_pend_ff, wb_dat_i, wb_sel_i);
	wire tmo_ok = tmo_w >= `CMDD_TMO_MIN;
	wire gt_ok = (gt_w >= `CMDD_GT_MIN) & (gt_w <= `CMDD_GT_MAX);
	wire [2:0] sd_req = wb_dat_i[`CMDD_CMD_SD_HI:`CMDD_CMD_SD_LO];
	wire do_exit = wr_cmd & wb_sel_i[0] & wb_dat_i[`CMDD_CMD_EXIT];
	wire do_apply = wr_cmd & wb_sel_i[0] & wb_dat_i[`CMDD_CMD_APPLY];
	wire do_scan = wr_cmd & wb_sel_i[0] & wb_sel_i[1] &
		wb_dat_i[`CMDD_CMD_SCAN] & (sd_req <= `CMDD_SD_MAX) &
		(sc_st_ff == cmdd_pkg::SC_IDLE);
	wire valid_cmd = wr_cmd | cmd_valid;
	wire vl_present = FW_REV <= `CMDD_VL_LAST_FW;
	wire scan_busy = sc_st_ff != cmdd_pkg::SC_IDLE;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
		`CMDD_A_CMD:
		begin
			rd_mux[`CMDD_ST_CMD] = cmd_mode_ff;
			rd_mux[`CMDD_ST_SCAN] = scan_busy;
		end
		`CMDD_A_TMO: rd_mux[15:0] = tmo_pend_ff;
		`CMDD_A_GUARD: rd_mux[15:0] = gt_pend_ff;
		`CMDD_A_ESC: rd_mux[7:0] = esc_pend_ff;
		`CMDD_A_CCA: rd_mux[7:0] = cca_pend_ff;
		`CMDD_A_BUSYCNT: rd_mux[15:0] = fail_cnt_ff[0];
		`CMDD_A_ACKCNT: rd_mux[15:0] = fail_cnt_ff[1];
		`CMDD_A_RSSI: rd_mux[7:0] = rssi_ff;
		`CMDD_A_FWREV: rd_mux[15:0] = FW_REV;
		`CMDD_A_HWREV: rd_mux[15:0] = HW_REV;
		`CMDD_A_VERBOSE: rd_mux = vl_present ? VERBOSE_INFO : 32'h0000_0000;
		`CMDD_A_IRQST: rd_mux[`CMDD_IRQ_W-1:0] = irq_st_ff;
		`CMDD_A_IRQMSK: rd_mux[`CMDD_IRQ_W-1:0] = irq_msk_ff;
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_ff <= wb_hit;
			wb_dat_ff <= (wb_hit & ~wb_we_i) ? rd_mux : wb_dat_ff;
		end
	end

	// ----------------------------------------------------------------
	// queued and active settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tmo_pend_ff <= `CMDD_TMO_RST;
			gt_pend_ff <= `CMDD_GT_RST;
			esc_pend_ff <= `CMDD_ESC_RST;
			cca_pend_ff <= CCA_THRESHOLD_RST;
		end
		else
		begin
			tmo_pend_ff <= (wr_tmo & tmo_ok) ? tmo_w : tmo_pend_ff;
			gt_pend_ff <= (wr_gt & gt_ok) ? gt_w : gt_pend_ff;
			esc_pend_ff <= wr_esc ? wb_dat_i[7:0] : esc_pend_ff;
			cca_pend_ff <= wr_cca ? wb_dat_i[7:0] : cca_pend_ff;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tmo_ff <= `CMDD_TMO_RST;
			gt_ff <= `CMDD_GT_RST;
			esc_ff <= `CMDD_ESC_RST;
			cca_ff <= CCA_THRESHOLD_RST;
			cfg_reinit_ff <= 1'b0;
		end
		else
		begin
			tmo_ff <= do_apply ? tmo_pend_ff : tmo_ff;
			gt_ff <= do_apply ? gt_pend_ff : gt_ff;
			esc_ff <= do_apply ? esc_pend_ff : esc_ff;
			cca_ff <= do_apply ? cca_pend_ff : cca_ff;
			cfg_reinit_ff <= do_apply;
		end
	end

	// ----------------------------------------------------------------
	// escape sequence and command mode
	// ----------------------------------------------------------------
	wire rx_esc = rx_in.valid & (rx_in.data == esc_ff);
	wire guard_met = silence_ff >= gt_ff;
	wire enter_cmd = (esc_st_ff == cmdd_pkg::ESC_THREE) & ~rx_in.valid &
		guard_met;
	wire timeout_hit = cmd_mode_ff & (idle_cnt_ff >= tmo_ff);
	wire leave_evt = cmd_mode_ff & (do_exit | timeout_hit);
	wire [15:0] nxt_silence = rx_in.valid ? 16'h0000 :
		((tick_ms & (silence_ff != `CMDD_CNT_MAX)) ? silence_ff + 16'h0001 :
		silence_ff);
	wire [15:0] nxt_idle = (valid_cmd | enter_cmd) ? 16'h0000 :
		((tick_100ms & (idle_cnt_ff != `CMDD_CNT_MAX)) ?
		idle_cnt_ff + 16'h0001 : idle_cnt_ff);

	always_comb
	begin
		nxt_esc_st = esc_st_ff;
		case (esc_st_ff)
		cmdd_pkg::ESC_DATA:
			if (rx_esc & guard_met & ~cmd_mode_ff)
				nxt_esc_st = cmdd_pkg::ESC_ONE;
		cmdd_pkg::ESC_ONE:
			if (rx_in.valid)
				nxt_esc_st = rx_esc ? cmdd_pkg::ESC_TWO : cmdd_pkg::ESC_DATA;
		cmdd_pkg::ESC_TWO:
			if (rx_in.valid)
				nxt_esc_st = rx_esc ? cmdd_pkg::ESC_THREE : cmdd_pkg::ESC_DATA;
		cmdd_pkg::ESC_THREE:
			if (rx_in.valid | guard_met)
				nxt_esc_st = cmdd_pkg::ESC_DATA;
		default: nxt_esc_st = cmdd_pkg::ESC_DATA;
		endcase
		if (do_apply)
			nxt_esc_st = cmdd_pkg::ESC_DATA;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			esc_st_ff <= cmdd_pkg::ESC_DATA;
			silence_ff <= 16'h0000;
			idle_cnt_ff <= 16'h0000;
			cmd_mode_ff <= 1'b0;
		end
		else
		begin
			esc_st_ff <= nxt_esc_st;
			silence_ff <= do_apply ? 16'h0000 : nxt_silence;
			idle_cnt_ff <= nxt_idle;
			cmd_mode_ff <= enter_cmd | (cmd_mode_ff & ~leave_evt);
		end
	end

	// ----------------------------------------------------------------
	// failure counters and signal strength
	// ----------------------------------------------------------------
	wire [1:0] cnt_evt = {ack_fail, cca_fail};
	wire [1:0] cnt_wr = {wr_ack, wr_busy};

	for (genvar i = 0; i < 2; i++)
	begin : g_fail
		wire clr = cnt_wr[i] &
			(wmerge16(fail_cnt_ff[i], wb_dat_i, wb_sel_i) == 16'h0000);
		wire inc = cnt_evt[i] & (fail_cnt_ff[i] != `CMDD_CNT_MAX);
		wire [15:0] nxt_cnt = clr ? {15'h0000, cnt_evt[i]} :
			(inc ? fail_cnt_ff[i] + 16'h0001 : fail_cnt_ff[i]);
		always_ff @(posedge clk)
		begin
			if (reset)
				fail_cnt_ff[i] <= 16'h0000;
			else
				fail_cnt_ff[i] <= nxt_cnt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			rssi_ff <= 8'h00;
		else
			rssi_ff <= rx_good ? rx_rssi : rssi_ff;
	end

	// ----------------------------------------------------------------
	// energy scan
	// ----------------------------------------------------------------
	wire [6:0] dwell_units = 7'(7'h01 << sc_exp_ff);
	wire [7:0] peak_now = (energy_level < sc_peak_ff) ? energy_level : sc_peak_ff;

	always_comb
	begin
		nxt_sc_st = sc_st_ff;
		nxt_sc_units = sc_units_ff;
		nxt_sc_ch = sc_ch_ff;
		nxt_sc_peak = sc_peak_ff;
		nxt_scan_tx = scan_tx_ff;
		scan_start_dwell = 1'b0;
		scan_done = 1'b0;
		case (sc_st_ff)
		cmdd_pkg::SC_IDLE:
			if (do_scan)
			begin
				nxt_sc_st = cmdd_pkg::SC_DWELL;
				nxt_sc_units = 7'h00;
				nxt_sc_ch = 4'h0;
				nxt_sc_peak = `CMDD_PEAK_RST;
				scan_start_dwell = 1'b1;
			end
		cmdd_pkg::SC_DWELL:
		begin
			nxt_sc_peak = peak_now;
			if (tick_scan)
			begin
				nxt_sc_units = sc_units_ff + 7'h01;
				if (sc_units_ff + 7'h01 == dwell_units)
				begin
					nxt_sc_st = cmdd_pkg::SC_PEAK;
					nxt_scan_tx = '{valid: 1'b1, data: peak_now};
				end
			end
		end
		cmdd_pkg::SC_PEAK:
			if (scan_tx_ready)
			begin
				nxt_sc_st = cmdd_pkg::SC_CR;
				nxt_scan_tx = '{valid: 1'b1, data: `CMDD_CR};
			end
		cmdd_pkg::SC_CR:
			if (scan_tx_ready)
			begin
				nxt_scan_tx = '{valid: 1'b0, data: 8'h00};
				nxt_sc_units = 7'h00;
				nxt_sc_peak = `CMDD_PEAK_RST;
				if (sc_ch_ff == `CMDD_LAST_CH)
				begin
					nxt_sc_st = cmdd_pkg::SC_IDLE;
					scan_done = 1'b1;
				end
				else
				begin
					nxt_sc_st = cmdd_pkg::SC_DWELL;
					nxt_sc_ch = sc_ch_ff + 4'h1;
					scan_start_dwell = 1'b1;
				end
			end
		default: nxt_sc_st = cmdd_pkg::SC_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sc_st_ff <= cmdd_pkg::SC_IDLE;
			sc_exp_ff <= 3'h0;
			sc_units_ff <= 7'h00;
			sc_ch_ff <= 4'h0;
			sc_peak_ff <= `CMDD_PEAK_RST;
			scan_tx_ff <= '{valid: 1'b0, data: 8'h00};
		end
		else
		begin
			sc_st_ff <= nxt_sc_st;
			sc_exp_ff <= do_scan ? sd_req : sc_exp_ff;
			sc_units_ff <= nxt_sc_units;
			sc_ch_ff <= nxt_sc_ch;
			sc_peak_ff <= nxt_sc_peak;
			scan_tx_ff <= nxt_scan_tx;
		end
	end

	cmdd_ticks #(
		.MS_CYCLES(MS_CYCLES),
		.SCAN_CYCLES(SCAN_CYCLES)
	) u_ticks (
		.clk(clk),
		.reset(reset),
		.scan_clear(scan_start_dwell),
		.tick_ms(tick_ms),
		.tick_100ms(tick_100ms),
		.tick_scan(tick_scan)
	);

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	wire [`CMDD_IRQ_W-1:0] irq_evt = {scan_done, leave_evt, enter_cmd};
	wire [`CMDD_IRQ_W-1:0] irq_clr = wr_irqst ? wb_dat_i[`CMDD_IRQ_W-1:0] :
		'0;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			irq_st_ff <= '0;
			irq_msk_ff <= '0;
		end
		else
		begin
			irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_evt;
			irq_msk_ff <= wr_irqmsk ? wb_dat_i[`CMDD_IRQ_W-1:0] : irq_msk_ff;
		end
	end

	assign wb_ack_o = wb_ack_ff;
	assign wb_dat_o = wb_dat_ff;
	assign scan_tx = scan_tx_ff;
	assign scan_channel = sc_ch_ff;
	assign scan_active = scan_busy;
	assign cmd_mode = cmd_mode_ff;
	assign cca_threshold = cca_ff;
	assign cfg_reinit = cfg_reinit_ff;
	assign irq = |(irq_st_ff & irq_msk_ff);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_peak_taken;
		sc_st_ff == cmdd_pkg::SC_PEAK && scan_tx_ready;
	endsequence
	sequence s_cr_out;
		sc_st_ff == cmdd_pkg::SC_CR && scan_tx.valid && scan_tx.data == `CMDD_CR;
	endsequence

	AST_TIMEOUT: assert property (cmd_mode_ff && idle_cnt_ff >= tmo_ff |=> !cmd_mode)
		else $error("command mode outlived its timeout");
	AST_EXIT: assert property (cmd_mode_ff && do_exit |=> !cmd_mode)
		else $error("exit command did not leave command mode");
	AST_GUARD: assert property ($rose(cmd_mode) |-> $past(silence_ff) >= $past(gt_ff))
		else $error("command mode entered without trailing silence");
	AST_ESCCHAR: assert property (esc_st_ff == cmdd_pkg::ESC_DATA && nxt_esc_st == cmdd_pkg::ESC_ONE |-> rx_in.data == esc_ff)
		else $error("wrong character started escape sequence");
	AST_APPLY: assert property (do_apply |=> cfg_reinit && tmo_ff == $past(tmo_pend_ff) && esc_ff == $past(esc_pend_ff))
		else $error("apply did not commit queued settings");
	AST_BUSYSAT: assert property (fail_cnt_ff[0] == `CMDD_CNT_MAX && !wr_busy |=> fail_cnt_ff[0] == `CMDD_CNT_MAX)
		else $error("busy failure counter wrapped");
	AST_ACKINC: assert property (ack_fail && !wr_ack && fail_cnt_ff[1] != `CMDD_CNT_MAX |=> fail_cnt_ff[1] == $past(fail_cnt_ff[1]) + 16'h0001)
		else $error("ack failure not counted");
	AST_CLEAR: assert property (wr_busy && wb_sel_i[1:0] == 2'h3 && wb_dat_i[15:0] == 16'h0000 && !cca_fail |=> fail_cnt_ff[0] == 16'h0000)
		else $error("zero write did not clear counter");
	AST_RSSI: assert property (rx_good |=> rssi_ff == $past(rx_rssi) ##1 ($past(rx_good) || $stable(rssi_ff)))
		else $error("signal strength not held");
	AST_SCANCR: assert property (s_peak_taken |=> s_cr_out)
		else $error("peak value not followed by carriage return");
	AST_SEQ: assert property (rx_in.valid && rx_in.data != esc_ff |=> esc_st_ff == cmdd_pkg::ESC_DATA)
		else $error("non-escape byte did not abort sequence");

endmodule

/* File: common/cmdd_defs.svh */
// constants for the command-mode and diagnostics block
`ifndef CMDD_DEFS_SVH
`define CMDD_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMDD_CLK_MHZ 25
`define CMDD_TICK_MS_US 1000
`define CMDD_SCAN_BASE_US 15360
`define CMDD_MS_PER_100 7'h63
`define CMDD_MS_CW 15
`define CMDD_SCAN_CW 19

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMDD_A_CMD 8'h00
`define CMDD_A_TMO 8'h04
`define CMDD_A_GUARD 8'h08
`define CMDD_A_ESC 8'h0C
`define CMDD_A_CCA 8'h10
`define CMDD_A_BUSYCNT 8'h14
`define CMDD_A_ACKCNT 8'h18
`define CMDD_A_RSSI 8'h1C
`define CMDD_A_FWREV 8'h20
`define CMDD_A_HWREV 8'h24
`define CMDD_A_VERBOSE 8'h28
`define CMDD_A_IRQST 8'h2C
`define CMDD_A_IRQMSK 8'h30

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CMDD_CMD_EXIT 0
`define CMDD_CMD_APPLY 1
`define CMDD_CMD_SCAN 2
`define CMDD_CMD_SD_HI 10
`define CMDD_CMD_SD_LO 8
`define CMDD_ST_CMD 0
`define CMDD_ST_SCAN 1
`define CMDD_IRQ_ENTER 0
`define CMDD_IRQ_LEAVE 1
`define CMDD_IRQ_SCAN 2
`define CMDD_IRQ_W 3

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define CMDD_TMO_RST 16'h0064
`define CMDD_TMO_MIN 16'h0002
`define CMDD_GT_RST 16'h03E8
`define CMDD_GT_MIN 16'h0002
`define CMDD_GT_MAX 16'h0CE4
`define CMDD_ESC_RST 8'h2B
`define CMDD_SD_MAX 3'h6
`define CMDD_VL_LAST_FW 16'h10C8
`define CMDD_CR 8'h0D
`define CMDD_PEAK_RST 8'hFF
`define CMDD_CNT_MAX 16'hFFFF
`define CMDD_LAST_CH 4'hF

`endif

/* File: common/cmdd_pkg.sv */
// types shared by the command-mode and diagnostics block
package cmdd_pkg;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cmdd_byte_s;

	typedef enum logic [1:0] {ESC_DATA, ESC_ONE, ESC_TWO, ESC_THREE} cmdd_esc_e;

	typedef enum logic [1:0] {SC_IDLE, SC_DWELL, SC_PEAK, SC_CR} cmdd_scan_e;

endpackage

/* File: src/cmdd_ticks.sv */
// millisecond, 100 ms and scan-base tick generator
`timescale 1ns/1ps
`include "cmdd_defs.svh"

module cmdd_ticks #(
	parameter int MS_CYCLES = `CMDD_CLK_MHZ * `CMDD_TICK_MS_US,
	parameter int SCAN_CYCLES = `CMDD_CLK_MHZ * `CMDD_SCAN_BASE_US
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic scan_clear,
	output logic tick_ms,
	output logic tick_100ms,
	output logic tick_scan
);

	logic [`CMDD_MS_CW-1:0] ms_cnt_ff;
	logic [6:0] hund_cnt_ff;
	logic [`CMDD_SCAN_CW-1:0] scan_cnt_ff;
	logic tick_ms_ff;
	logic tick_100ms_ff;
	logic tick_scan_ff;

	wire ms_wrap = ms_cnt_ff == `CMDD_MS_CW'(MS_CYCLES - 1);
	wire hund_wrap = ms_wrap & (hund_cnt_ff == `CMDD_MS_PER_100);
	wire scan_wrap = scan_cnt_ff == `CMDD_SCAN_CW'(SCAN_CYCLES - 1);
	wire [`CMDD_MS_CW-1:0] nxt_ms_cnt = ms_wrap ? '0 : ms_cnt_ff + 1'b1;
	wire [6:0] nxt_hund_cnt = hund_wrap ? 7'h00 :
		(ms_wrap ? hund_cnt_ff + 7'h01 : hund_cnt_ff);
	// scan base restarts so each dwell starts on a full period
	wire [`CMDD_SCAN_CW-1:0] nxt_scan_cnt = (scan_clear | scan_wrap) ? '0 :
		scan_cnt_ff + 1'b1;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ms_cnt_ff <= '0;
			hund_cnt_ff <= 7'h00;
			scan_cnt_ff <= '0;
			tick_ms_ff <= 1'b0;
			tick_100ms_ff <= 1'b0;
			tick_scan_ff <= 1'b0;
		end
		else
		begin
			ms_cnt_ff <= nxt_ms_cnt;
			hund_cnt_ff <= nxt_hund_cnt;
			scan_cnt_ff <= nxt_scan_cnt;
			tick_ms_ff <= ms_wrap;
			tick_100ms_ff <= hund_wrap;
			tick_scan_ff <= scan_wrap & ~scan_clear;
		end
	end

	assign tick_ms = tick_ms_ff;
	assign tick_100ms = tick_100ms_ff;
	assign tick_scan = tick_scan_ff;

endmodule

/* File: verif/cmdd_host_model.sv */
// host-side serial byte source and scan byte sink
`timescale 1ns/1ps
module cmdd_host_model (
	input wire logic clk,
	input wire logic slow,
	output cmdd_pkg::cmdd_byte_s rx_in,
	output logic scan_tx_ready
);
	logic ph_ff = 1'b0;
	initial rx_in = {1'b0, 8'hA5};
	// ----------------------------------------------------------------
	// serial bytes: sent only on request, the caller keeps the silences
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_in <= {1'b1, b};
		@(posedge clk);
		// idle data shows the inverse so a stale byte is never reused
		rx_in <= {1'b0, ~b};
	endtask
	// ----------------------------------------------------------------
	// scan sink: prompt, or stalls every other cycle
	// ----------------------------------------------------------------
	always @(posedge clk) ph_ff <= ~ph_ff;
	assign scan_tx_ready = slow ? ph_ff : 1'b1;
endmodule

/* File: verif/tb_cmdd_core.sv */
// self-checking bench for the command-mode and diagnostics block
`timescale 1ns/1ps
`include "cmdd_defs.svh"
module tb_cmdd_core;
	localparam int MS = 20;
	localparam int SC = 30;
	localparam logic [15:0] FW = 16'h10C8; // arbitrary value
	localparam logic [15:0] HW = 16'h0A55; // arbitrary value
	localparam logic [31:0] VI = 32'h0000_5A5A;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic cmd_valid = 1'b0;
	logic [1:0] evt = 2'h0;
	logic rx_good = 1'b0;
	logic [7:0] rx_rssi = 8'h00;
	logic [7:0] energy = 8'h00;
	logic slow = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic scan_tx_ready;
	logic scan_active;
	logic cmd_mode;
	logic [7:0] cca_threshold;
	logic irq;
	logic cfg_reinit;
	logic [3:0] scan_channel;
	cmdd_pkg::cmdd_byte_s rx_in;
	cmdd_pkg::cmdd_byte_s scan_tx;
	int errors = 0;
	int samples_checked = 0;
	logic [15:0] rnd = 16'hBC53; // lfsr seed 48211
	logic [31:0] rq[$];
	logic [31:0] sq[$];

	initial forever #20 clk = ~clk;

	cmdd_core #(.MS_CYCLES(MS), .SCAN_CYCLES(SC), .FW_REV(FW), .HW_REV(HW),
		.VERBOSE_INFO(VI), .CCA_THRESHOLD_RST(8'h00)) i_cmdd_core (
		.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_in(rx_in),
		.cmd_valid(cmd_valid), .cca_fail(evt[0]), .ack_fail(evt[1]),
		.rx_good(rx_good), .rx_rssi(rx_rssi), .energy_level(energy),
		.scan_tx(scan_tx), .scan_tx_ready(scan_tx_ready),
		.scan_channel(scan_channel), .scan_active(scan_active),
		.cmd_mode(cmd_mode), .cca_threshold(cca_threshold),
		.cfg_reinit(cfg_reinit), .irq(irq));

	cmdd_host_model i_cmdd_host_model (.clk(clk), .slow(slow),
		.rx_in(rx_in), .scan_tx_ready(scan_tx_ready));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// wishbone classic cycle, held until ack is sampled
	// ----------------------------------------------------------------
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask

	// mode 1 breaks the triple, mode 2 talks in the trailing silence
	task automatic esc_seq(input logic [7:0] c, input int m, input logic e);
		repeat (3 * MS) @(posedge clk);
		i_cmdd_host_model.send(c);
		if (m == 1) i_cmdd_host_model.send(8'h0A);
		i_cmdd_host_model.send(c);
		i_cmdd_host_model.send(c);
		repeat (MS / 2) @(posedge clk);
		if (m == 2) i_cmdd_host_model.send(8'h0A);
		repeat (3 * MS) @(posedge clk);
		chk("cmd_mode", {31'h0, cmd_mode}, {31'h0, e});
	endtask

	// ----------------------------------------------------------------
	// result watcher: oldest note against each answer
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		if (wb_ack_o === 1'b1 && !we)
			chk("rdata", wb_dat_o, rq.size() ? rq.pop_front() : 'x);
		if (scan_tx.valid === 1'b1 && scan_tx_ready)
			chk("scan", {24'h0, scan_tx.data}, sq.size() ? sq.pop_front() : 'x);
	end

	initial
	begin
		repeat (95000) @(posedge clk);
		errors++;
		wrap_up;
	end

	initial
	begin
		logic [7:0] c;
		logic [7:0] a;
		int n;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(`CMDD_A_TMO, 32'h0000_0064);
		rd(`CMDD_A_GUARD, 32'h0000_03E8);
		rd(`CMDD_A_ESC, 32'h0000_002B);
		rd(8'h3C, 32'h0000_0000);
		rd(`CMDD_A_VERBOSE, VI);
		wr(`CMDD_A_FWREV, 32'h0000_FFFF);
		wr(`CMDD_A_HWREV, 32'h0000_FFFF);
		rd(`CMDD_A_FWREV, {16'h0, FW});
		rd(`CMDD_A_HWREV, {16'h0, HW});
		wr(`CMDD_A_IRQMSK, 32'h0);
		$display("test reset values done");
		rnd = lfsr(rnd);
		c = {1'b1, rnd[6:0]};
		wr(`CMDD_A_ESC, {24'h0, c});
		wr(`CMDD_A_CCA, {24'h0, 1'b1, rnd[14:8]});
		wr(`CMDD_A_GUARD, 32'h0000_0002);
		wr(`CMDD_A_GUARD, 32'h0000_0CE5);
		wr(`CMDD_A_TMO, 32'h0000_0001);
		rd(`CMDD_A_GUARD, 32'h0000_0002);
		rd(`CMDD_A_TMO, 32'h0000_0064);
		rd(`CMDD_A_ESC, {24'h0, c});
		chk("cca_threshold", {24'h0, cca_threshold}, 32'h0);
		wr(`CMDD_A_CMD, 32'h0000_0002);
		@(posedge clk);
		chk("cca_threshold", {24'h0, cca_threshold}, {25'h0, rnd[14:8]} | 32'h80);
		chk("cfg_reinit", {31'h0, cfg_reinit}, 32'h1);
		$display("test apply done");
		for (int m = 1; m < 3; m++) esc_seq(c, m, 1'b0);
		esc_seq(c, 0, 1'b1);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(`CMDD_A_IRQMSK, 32'h0000_0007);
		@(posedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(`CMDD_A_IRQST, 32'h0000_0001);
		wr(`CMDD_A_IRQST, 32'h0000_0001);
		@(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(`CMDD_A_CMD, 32'h0000_0001);
		@(posedge clk);
		chk("cmd_mode", {31'h0, cmd_mode}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(`CMDD_A_IRQST, 32'h0000_0002);
		$display("test escape and exit done");
		wr(`CMDD_A_TMO, 32'h0000_0002);
		wr(`CMDD_A_CMD, 32'h0000_0002);
		esc_seq(c, 0, 1'b1);
		repeat (1500) @(posedge clk);
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		repeat (1900) @(posedge clk);
		chk("cmd_mode", {31'h0, cmd_mode}, 32'h1);
		repeat (2300) @(posedge clk);
		chk("cmd_mode", {31'h0, cmd_mode}, 32'h0);
		$display("test timeout done");
		for (int k = 0; k < 2; k++)
		begin
			rnd = lfsr(rnd);
			n = rnd[3:0] + 1;
			a = k ? `CMDD_A_ACKCNT : `CMDD_A_BUSYCNT;
			repeat (n) @(posedge clk) evt <= 2'h1 << k;
			@(posedge clk) evt <= 2'h0;
			rd(a, 32'(n));
			wr(a, 32'h0000_0005);
			rd(a, 32'(n));
			wr(a, 32'h0000_0000);
			rd(a, 32'h0000_0000);
		end
		@(posedge clk) evt <= 2'h1;
		repeat (65537) @(posedge clk);
		evt <= 2'h0;
		rd(`CMDD_A_BUSYCNT, 32'h0000_FFFF);
		$display("test counters done");
		repeat (2)
		begin
			rnd = lfsr(rnd);
			@(posedge clk);
			rx_good <= 1'b1;
			rx_rssi <= {2'h0, rnd[5:0]} + 8'h17;
			@(posedge clk);
			rx_good <= 1'b0;
			rx_rssi <= ~rx_rssi;
		end
		wr(`CMDD_A_RSSI, 32'h0000_0000);
		rd(`CMDD_A_RSSI, {24'h0, {2'h0, rnd[5:0]} + 8'h17});
		$display("test signal strength done");
		wr(`CMDD_A_IRQST, 32'h0000_0007);
		wr(`CMDD_A_CMD, 32'h0000_0704);
		rd(`CMDD_A_CMD, 32'h0000_0000);
		rnd = lfsr(rnd);
		energy <= rnd[7:0];
		slow <= 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			sq.push_back({24'h0, rnd[7:0]});
			sq.push_back({24'h0, `CMDD_CR});
		end
		wr(`CMDD_A_CMD, 32'h0000_0104);
		n = 0;
		while (scan_tx.valid !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk("dwell", {31'h0, n >= 56 && n <= 66}, 32'h1);
		n = 0;
		while (scan_active !== 1'b0 && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		chk("scan left", sq.size(), 32'h0);
		chk("scan_channel", {28'h0, scan_channel}, {28'h0, `CMDD_LAST_CH});
		rd(`CMDD_A_IRQST, 32'h0000_0004);
		wr(`CMDD_A_IRQST, 32'h0000_0004);
		@(posedge clk);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test scan done");
		wrap_up;
	end
endmodule
